// *** core_context_regs.sv ***
// Core context state register bank: status word control fields, previous-context
// link, free list head and limit pointers, running stack pointer and interrupt
// stack base, with automatic stack switch on interrupt entry.
// Assumes the execution logic on the same clock issues privileged moves and
// context events as one-cycle strobes.
//
// Notes on behaviour
// - Protection set select lives in status word bits 13:12.
// - Select values 00 to 11 choose protection set 0 to 3.
// - Privilege field 11:10 decodes user0, user1, supervisor, reserved.
// - Status bit 9 set means the task runs on the interrupt stack.
// - Global address register writes blocked while status bit 8 is 0.
// - Count enable 0 suspends depth counting; next call sets it to 1.
// - All-ones depth field disables counting regardless of the enable bit.
// - Depth field is leading ones, a zero, then the counter bits.
// - Link bits 31:24 hold the interrupted task's priority number.
// - Link bit 23 holds the interrupted task's interrupt enable.
// - Link bit 22 tags upper or lower context; a mismatch on restore traps.
// - Previous-context pointer is segment 19:16 and offset 15:0 of the link.
// - Pointers are 16-bit offset plus 4-bit segment; areas are 64 bytes.
// - One offset step moves the address sixteen words; 64K areas per segment.
// - Free list head pointer designates an available save area.
// - Head equal to limit on call or interrupt saves, then depletion trap.
// - Limit pointer designates the last available save area.
// - General address register ten is the running task's stack pointer.
// - Interrupt with flag 0 saves the stack pointer, then loads interrupt base.
// - Interrupt with flag already 1 leaves the stack pointer alone.
// - Interrupt stack base may be rewritten at any time.
`timescale 1ns/1ps
`default_nettype none
`include "core_context_defines.svh"

module core_context_regs
    import core_context_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    // Privileged move-to and move-from core register port.
    input wire logic moveWrite,
    input wire core_context_pkg::reg_select_t moveSelect,
    input wire logic [31:0] moveWriteData,
    output logic [31:0] moveReadData,
    // Context events from the execution logic.
    input wire logic callExec,
    input wire logic callCountStep,
    input wire logic interruptTake,
    input wire logic [7:0] currentPriority,
    input wire logic currentIrqEnable,
    input wire logic contextSave,
    input wire logic saveUpper,
    input wire logic [31:0] newFreeHead,
    input wire logic restoreExec,
    input wire logic restoreExpectUpper,
    input wire logic stackWrite,
    input wire logic [31:0] stackWriteData,
    input wire logic globalRegWriteReq,
    // Decoded state for the rest of the core.
    output logic [3:0] protectionSetOneHot,
    output core_context_pkg::periph_priv_t periphPrivilege,
    output logic privilegeReserved,
    output logic globalRegWriteAllow,
    output logic callDepthCounting,
    output logic [6:0] callDepthMask,
    output logic [6:0] callDepthCount,
    output logic [31:0] freeHeadAddress,
    output logic [31:0] previousContextAddress,
    output logic depletionTrap,
    output logic contextKindTrap,
    output logic stackSaveStrobe,
    output logic [31:0] stackSaveValue,
    output logic [31:0] stackPointer,
    output logic interruptStackInUse
);

    ////////////////////////////////////////////////////////////////////////////

    logic [31:0] programStatusWord_reg;
    logic [31:0] programStatusWord_next;
    logic [31:0] previousContextLink_reg;
    logic [31:0] previousContextLink_next;
    logic [31:0] freeListHeadPointer_reg;
    logic [31:0] freeListHeadPointer_next;
    logic [31:0] freeListLimitPointer_reg;
    logic [31:0] freeListLimitPointer_next;
    logic [31:0] runningStackPointer_reg;
    logic [31:0] runningStackPointer_next;
    logic [31:0] interruptStackBase_reg;
    logic [31:0] interruptStackBase_next;
    logic depletionTrap_reg;
    logic contextKindTrap_reg;
    logic stackSaveStrobe_reg;
    logic [31:0] stackSaveValue_reg;
    entry_state_t entryState_reg;
    entry_state_t entryState_next;

    function automatic logic selHit(input reg_select_t sel, input reg_select_t code);
        selHit = moveWrite && (sel == code);
    endfunction : selHit

    wire writePsw = selHit(moveSelect, `SEL_PSW);
    wire writeLink = selHit(moveSelect, `SEL_LINK);
    wire writeHead = selHit(moveSelect, `SEL_FREE_HEAD);
    wire writeLimit = selHit(moveSelect, `SEL_FREE_LIMIT);
    wire writeStack = selHit(moveSelect, `SEL_STACK);
    wire writeIstack = selHit(moveSelect, `SEL_ISTACK);

    ////////////////////////////////////////////////////////////////////////////
    // Status word decoding.

    wire [1:0] protectionSet = programStatusWord_reg[`PSW_PRS_HI:`PSW_PRS_LO];
    wire [1:0] privField = programStatusWord_reg[`PSW_PRIV_HI:`PSW_PRIV_LO];
    wire stackInUse = programStatusWord_reg[`PSW_IS_BIT];
    wire globalWritePermit = programStatusWord_reg[`PSW_GW_BIT];
    wire countEnable = programStatusWord_reg[`PSW_CDE_BIT];
    wire [6:0] depthField = programStatusWord_reg[`PSW_CDC_HI:0];

    assign protectionSetOneHot = 4'h1 << protectionSet;
    assign periphPrivilege = periph_priv_t'(privField);
    assign privilegeReserved = (privField == PRIV_RESERVED);
    assign globalRegWriteAllow = globalRegWriteReq && globalWritePermit;
    assign callDepthCounting = countEnable && (depthField != `CDC_ALL_ONES);
    assign stackPointer = runningStackPointer_reg;
    assign interruptStackInUse = stackInUse;

    // The mask is every bit above the first zero from the top, that zero included.
    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < 7; bitIdx = bitIdx + 1)
        begin : gen_depth_split
            wire allOnesAbove = &depthField[6:bitIdx];
            wire inMask;
            if (bitIdx == 6)
            begin : gen_top
                assign inMask = 1'b1;
            end
            else
            begin : gen_rest
                assign inMask = &depthField[6:bitIdx + 1];
            end
            assign callDepthMask[bitIdx] = inMask;
            assign callDepthCount[bitIdx] = !inMask && depthField[bitIdx] && !allOnesAbove;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Save area addressing and list depletion.

    save_area_address u_head_address
    (
        .pointer(freeListHeadPointer_reg),
        .address(freeHeadAddress)
    );

    save_area_address u_prev_address
    (
        .pointer(previousContextLink_reg & `PTR_MASK),
        .address(previousContextAddress)
    );

    wire headAtLimit = ((freeListHeadPointer_reg ^ freeListLimitPointer_reg) & `PTR_MASK)
                       == 32'h0000_0000;
    wire kindMismatch = previousContextLink_reg[`LINK_KIND_BIT] != restoreExpectUpper;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt entry: save the old stack pointer, then switch and mark the flag in the same cycle.

    always_comb
    begin
        entryState_next = entryState_reg;
        unique case (entryState_reg)
            ENTRY_IDLE:
                if (interruptTake)
                    entryState_next = ENTRY_SAVE;
            ENTRY_SAVE:
                entryState_next = ENTRY_SWITCH;
            ENTRY_SWITCH:
                entryState_next = ENTRY_IDLE;
            default:
                entryState_next = ENTRY_IDLE;
        endcase
    end

    wire inSave = (entryState_reg == ENTRY_SAVE);
    wire inSwitch = (entryState_reg == ENTRY_SWITCH);

    always_comb
    begin
        programStatusWord_next = programStatusWord_reg;
        if (writePsw)
            programStatusWord_next = moveWriteData & `PSW_CTRL_MASK;
        if (callExec && !countEnable)
            programStatusWord_next[`PSW_CDE_BIT] = 1'b1;
        if (callExec && callCountStep && callDepthCounting)
            programStatusWord_next[`PSW_CDC_HI:0] =
                depthField + (7'h01 & ~callDepthMask);
        if (inSwitch)
            programStatusWord_next[`PSW_IS_BIT] = 1'b1;
    end

    always_comb
    begin
        previousContextLink_next = previousContextLink_reg;
        if (writeLink)
            previousContextLink_next = moveWriteData & `LINK_MASK;
        if (contextSave)
        begin
            previousContextLink_next[`LINK_PRIO_HI:`LINK_PRIO_LO] = currentPriority;
            previousContextLink_next[`LINK_PIE_BIT] = currentIrqEnable;
            previousContextLink_next[`LINK_KIND_BIT] = saveUpper;
            previousContextLink_next[`PTR_SEG_HI:0] = freeListHeadPointer_reg[`PTR_SEG_HI:0];
        end
    end

    assign freeListHeadPointer_next = writeHead ? (moveWriteData & `PTR_MASK) :
                                      contextSave ? (newFreeHead & `PTR_MASK) :
                                      freeListHeadPointer_reg;
    assign freeListLimitPointer_next = writeLimit ? (moveWriteData & `PTR_MASK) :
                                       freeListLimitPointer_reg;
    assign interruptStackBase_next = writeIstack ? moveWriteData :
                                     interruptStackBase_reg;

    always_comb
    begin
        runningStackPointer_next = runningStackPointer_reg;
        if (writeStack)
            runningStackPointer_next = moveWriteData;
        if (stackWrite)
            runningStackPointer_next = stackWriteData;
        if (inSwitch && !stackInUse)
            runningStackPointer_next = interruptStackBase_reg;
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            programStatusWord_reg <= `PSW_RESET;
            previousContextLink_reg <= `LINK_RESET;
            freeListHeadPointer_reg <= `FREE_HEAD_RESET;
            freeListLimitPointer_reg <= `FREE_LIMIT_RESET;
            runningStackPointer_reg <= `STACK_RESET;
            interruptStackBase_reg <= `ISTACK_RESET;
            entryState_reg <= ENTRY_IDLE;
        end
        else
        begin
            programStatusWord_reg <= programStatusWord_next;
            previousContextLink_reg <= previousContextLink_next;
            freeListHeadPointer_reg <= freeListHeadPointer_next;
            freeListLimitPointer_reg <= freeListLimitPointer_next;
            runningStackPointer_reg <= runningStackPointer_next;
            interruptStackBase_reg <= interruptStackBase_next;
            entryState_reg <= entryState_next;
        end
    end

    // Trap and save strobes are one-cycle pulses; the save completes regardless.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            depletionTrap_reg <= 1'b0;
            contextKindTrap_reg <= 1'b0;
            stackSaveStrobe_reg <= 1'b0;
            stackSaveValue_reg <= 32'h0000_0000;
        end
        else
        begin
            depletionTrap_reg <= contextSave && (callExec || interruptTake || inSave)
                                 && headAtLimit;
            contextKindTrap_reg <= restoreExec && kindMismatch;
            stackSaveStrobe_reg <= inSave && !stackInUse;
            if (inSave)
                stackSaveValue_reg <= runningStackPointer_reg;
        end
    end

    assign depletionTrap = depletionTrap_reg;
    assign contextKindTrap = contextKindTrap_reg;
    assign stackSaveStrobe = stackSaveStrobe_reg;
    assign stackSaveValue = stackSaveValue_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Move-from read path; unknown selects read zero.

    always_comb
    begin
        moveReadData = 32'h0000_0000;
        unique case (moveSelect)
            `SEL_PSW: moveReadData = programStatusWord_reg;
            `SEL_LINK: moveReadData = previousContextLink_reg;
            `SEL_FREE_HEAD: moveReadData = freeListHeadPointer_reg;
            `SEL_FREE_LIMIT: moveReadData = freeListLimitPointer_reg;
            `SEL_STACK: moveReadData = runningStackPointer_reg;
            `SEL_ISTACK: moveReadData = interruptStackBase_reg;
            default: moveReadData = 32'h0000_0000;
        endcase
    end

endmodule : core_context_regs
`default_nettype wire

// *** core_context_defines.svh ***
// Field positions, reset values and selector codes for the core context state registers.
// Assumes it is included by bare name from the package and the design modules.
`ifndef CORE_CONTEXT_DEFINES_SVH
`define CORE_CONTEXT_DEFINES_SVH

`define PSW_RESET 32'h0000_0b80
`define PSW_PRS_HI 13
`define PSW_PRS_LO 12
`define PSW_PRIV_HI 11
`define PSW_PRIV_LO 10
`define PSW_IS_BIT 9
`define PSW_GW_BIT 8
`define PSW_CDE_BIT 7
`define PSW_CDC_HI 6
`define PSW_CTRL_MASK 32'h0000_3fff
`define LINK_RESET 32'h0000_0000
`define LINK_PRIO_HI 31
`define LINK_PRIO_LO 24
`define LINK_PIE_BIT 23
`define LINK_KIND_BIT 22
`define LINK_MASK 32'hffcf_ffff
`define PTR_MASK 32'h000f_ffff
`define PTR_SEG_HI 19
`define PTR_SEG_LO 16
`define PTR_OFS_HI 15
`define FREE_HEAD_RESET 32'h0000_0000
`define FREE_LIMIT_RESET 32'h0000_0000
`define STACK_RESET 32'h0000_0000
`define ISTACK_RESET 32'h0000_0000
`define CDC_ALL_ONES 7'h7f
`define SEL_PSW 3'h0
`define SEL_LINK 3'h1
`define SEL_FREE_HEAD 3'h2
`define SEL_FREE_LIMIT 3'h3
`define SEL_STACK 3'h4
`define SEL_ISTACK 3'h5

`endif

// *** core_context_pkg.sv ***
// Types shared by the core context state register bank.
// Assumes the defines header is on the include path.
`include "core_context_defines.svh"

package core_context_pkg;

    typedef logic [2:0] reg_select_t;

    typedef enum logic [1:0]
    {
        PRIV_USER0 = 2'h0,
        PRIV_USER1 = 2'h1,
        PRIV_SUPERVISOR = 2'h2,
        PRIV_RESERVED = 2'h3
    } periph_priv_t;

    typedef enum logic [2:0]
    {
        ENTRY_IDLE = 3'b001,
        ENTRY_SAVE = 3'b010,
        ENTRY_SWITCH = 3'b100
    } entry_state_t;

endpackage : core_context_pkg

// *** save_area_address.sv ***
// Forms the effective byte address of a context save area from a list pointer.
// Assumes a pointer laid out with segment in 19:16 and offset in 15:0.
`timescale 1ns/1ps
`default_nettype none
`include "core_context_defines.svh"

module save_area_address
(
    input wire logic [31:0] pointer,
    output logic [31:0] address
);

    // Each offset step moves one 64-byte save area, hence the six zero bits below.
    assign address = {pointer[`PTR_SEG_HI:`PTR_SEG_LO], 6'h00,
                      pointer[`PTR_OFS_HI:0], 6'h00};

endmodule : save_area_address
`default_nettype wire

// *** core_context_regs_assertions.sv ***
// Checker for the core context register bank, watching only its top-level ports.
// Assumes one clock, sys_clk, and an asynchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none

module core_context_regs_assertions
    import core_context_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic moveWrite,
    input wire core_context_pkg::reg_select_t moveSelect,
    input wire logic [31:0] moveReadData,
    input wire logic callExec,
    input wire logic interruptTake,
    input wire logic restoreExec,
    input wire logic restoreExpectUpper,
    input wire logic globalRegWriteReq,
    input wire logic [3:0] protectionSetOneHot,
    input wire core_context_pkg::periph_priv_t periphPrivilege,
    input wire logic privilegeReserved,
    input wire logic globalRegWriteAllow,
    input wire logic callDepthCounting,
    input wire logic [31:0] freeHeadAddress,
    input wire logic [31:0] previousContextAddress,
    input wire logic contextKindTrap,
    input wire logic stackSaveStrobe,
    input wire logic [31:0] stackSaveValue,
    input wire logic [31:0] stackPointer,
    input wire logic interruptStackInUse
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Field checks lean on the read port, so they only apply while it shows that register.
    a_prs_decode: assert property (moveSelect == 3'h0
        |-> protectionSetOneHot == 4'h1 << moveReadData[13:12]) else $error("set select bad");
    a_priv_decode: assert property (moveSelect == 3'h0 |-> periphPrivilege ==
        moveReadData[11:10] && privilegeReserved == &moveReadData[11:10]) else $error("priv bad");
    a_gw_gate: assert property (moveSelect == 3'h0
        |-> globalRegWriteAllow == (globalRegWriteReq && moveReadData[8])) else $error("gw bad");
    a_depth_gate: assert property (moveSelect == 3'h0 |-> callDepthCounting ==
        (moveReadData[7] && moveReadData[6:0] != 7'h7f)) else $error("depth gate bad");
    a_cde_rearm: assert property (callExec && !moveWrite && moveSelect == 3'h0 &&
        !moveReadData[7] |=> moveSelect != 3'h0 || moveReadData[7]) else $error("no rearm");
    a_head_addr: assert property (moveSelect == 3'h2 |-> freeHeadAddress ==
        {moveReadData[19:16], 6'h0, moveReadData[15:0], 6'h0}) else $error("head addr bad");
    a_link_addr: assert property (moveSelect == 3'h1 |-> previousContextAddress ==
        {moveReadData[19:16], 6'h0, moveReadData[15:0], 6'h0}) else $error("link addr bad");
    a_stack_save: assert property (interruptTake && !interruptStackInUse |-> ##2
        stackSaveStrobe && stackSaveValue == $past(stackPointer, 2)) else $error("no save");
    a_stack_keep: assert property (interruptTake && interruptStackInUse
        |-> ##2 !stackSaveStrobe) else $error("stack switched twice");
    a_flag_set: assert property (interruptTake |-> ##3 interruptStackInUse)
        else $error("stack flag not set");
    a_kind_trap: assert property (restoreExec && moveSelect == 3'h1 |=> contextKindTrap ==
        ($past(moveReadData[22]) != $past(restoreExpectUpper))) else $error("kind trap bad");

    c_switch: cover property (interruptTake && !interruptStackInUse);
    c_kind: cover property (contextKindTrap);
    c_rearm: cover property (callExec && !moveReadData[7] && moveSelect == 3'h0);
endmodule : core_context_regs_assertions

`default_nettype wire

// *** context_save_sink.sv ***
// Far-side model: the context save path that stores the stack pointer handed over.
// Assumes the bank's strobe is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module context_save_sink
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic stackSaveStrobe,
    input wire logic [31:0] stackSaveValue,
    output logic [31:0] savedStackReg,
    output logic [7:0] saveCountReg
);
    // Counting saves exposes a strobe that is too long as well as one that is missing.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            savedStackReg <= 32'h0000_0000;
            saveCountReg <= 8'h00;
        end
        else if (stackSaveStrobe)
        begin
            savedStackReg <= stackSaveValue;
            saveCountReg <= saveCountReg + 8'h01;
        end
    end
endmodule : context_save_sink

`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the core context register bank and its save-path model.
// Assumes the package and the checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module tb
    import core_context_pkg::*;
;
    logic sys_clk, rst, moveWrite = 1'b0, callExec = 1'b0, callCountStep = 1'b0;
    logic interruptTake = 1'b0, currentIrqEnable = 1'b0, contextSave = 1'b0, saveUpper = 1'b0;
    logic restoreExec = 1'b0, restoreExpectUpper = 1'b0, stackWrite = 1'b0;
    logic globalRegWriteReq = 1'b0;
    reg_select_t moveSelect = 3'h0;
    logic [7:0] currentPriority = 8'h00;
    logic [31:0] moveWriteData = 32'h0, newFreeHead = 32'h0, stackWriteData = 32'h0;
    logic [31:0] moveReadData, freeHeadAddress, previousContextAddress, stackSaveValue;
    logic [31:0] stackPointer, savedStackReg;
    logic [7:0] saveCountReg;
    logic [6:0] callDepthMask, callDepthCount;
    logic [3:0] protectionSetOneHot;
    periph_priv_t periphPrivilege;
    logic privilegeReserved, globalRegWriteAllow, callDepthCounting, depletionTrap;
    logic contextKindTrap, stackSaveStrobe, interruptStackInUse;
    int n_mismatch = 0;
    int compares = 0;
    int i;

    core_context_regs u_dut (.sys_clk, .rst, .moveWrite, .moveSelect, .moveWriteData,
        .moveReadData, .callExec, .callCountStep, .interruptTake, .currentPriority,
        .currentIrqEnable, .contextSave, .saveUpper, .newFreeHead, .restoreExec,
        .restoreExpectUpper, .stackWrite, .stackWriteData, .globalRegWriteReq,
        .protectionSetOneHot, .periphPrivilege, .privilegeReserved, .globalRegWriteAllow,
        .callDepthCounting, .callDepthMask, .callDepthCount, .freeHeadAddress,
        .previousContextAddress, .depletionTrap, .contextKindTrap, .stackSaveStrobe,
        .stackSaveValue, .stackPointer, .interruptStackInUse);
    context_save_sink u_sink (.sys_clk, .rst, .stackSaveStrobe, .stackSaveValue,
        .savedStackReg, .saveCountReg);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Writes end with an idle cycle so that moveWrite never drops and rises in one step.
    task automatic wr(input reg_select_t sel, input logic [31:0] d);
        moveWrite = 1'b1;
        moveSelect = sel;
        moveWriteData = d;
        tick;
        moveWrite = 1'b0;
        tick;
    endtask : wr
    task automatic rd(input reg_select_t sel, input logic [31:0] exp, input string what);
        moveSelect = sel;
        #5;
        check(what, exp, moveReadData);
        tick;
    endtask : rd
    task automatic save(input logic up, input logic [7:0] pr, input logic ie,
        input logic [31:0] nxt, input logic trap);
        contextSave = 1'b1;
        callExec = 1'b1;
        saveUpper = up;
        currentPriority = pr;
        currentIrqEnable = ie;
        newFreeHead = nxt;
        tick;
        contextSave = 1'b0;
        callExec = 1'b0;
        check("depletion trap", trap, depletionTrap);
        tick;
    endtask : save
    task automatic restore(input logic up, input logic trap);
        restoreExec = 1'b1;
        restoreExpectUpper = up;
        tick;
        restoreExec = 1'b0;
        check("kind trap", trap, contextKindTrap);
        tick;
    endtask : restore
    task automatic take_irq;
        interruptTake = 1'b1;
        tick;
        interruptTake = 1'b0;
        tick;
    endtask : take_irq
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (1000) @(posedge sys_clk);
        n_mismatch++;
        print_verdict;
    end
    initial
    begin
        rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        for (i = 0; i < 8; i++)
            rd(i[2:0], (i == 0) ? 32'h0000_0b80 : 32'h0, "reset value");
        $display("test reset values done");
        globalRegWriteReq = 1'b1;
        for (i = 0; i < 4; i++)
        begin
            wr(3'h0, 32'hffff_c100 | (i << 12) | (i << 10));
            rd(3'h0, 32'h0000_0100 | (i << 12) | (i << 10), "status word");
            check("protection set", 32'h1 << i, {28'h0, protectionSetOneHot});
            check("privilege", i, {30'h0, periphPrivilege});
            check("reserved flag", i == 3, {31'h0, privilegeReserved});
            check("global allow", 1, {31'h0, globalRegWriteAllow});
        end
        wr(3'h0, 32'h0000_0000);
        check("global allow", 0, {31'h0, globalRegWriteAllow});
        $display("test status fields done");
        wr(3'h0, 32'h0000_005e);
        check("depth counting", 0, {31'h0, callDepthCounting});
        for (i = 0; i < 2; i++)
        begin
            callExec = 1'b1;
            callCountStep = 1'b1;
            tick;
            callExec = 1'b0;
            callCountStep = 1'b0;
            rd(3'h0, 32'h0000_00de + i, "status word");
        end
        check("depth mask", 32'h0000_0060, {25'h0, callDepthMask});
        check("depth count", 32'h0000_001f, {25'h0, callDepthCount});
        wr(3'h0, 32'h0000_00ff);
        check("depth counting", 0, {31'h0, callDepthCounting});
        $display("test call depth done");
        wr(3'h2, 32'hfff3_1234);
        rd(3'h2, 32'h0003_1234, "free head");
        check("head address", 32'h3004_8d00, freeHeadAddress);
        wr(3'h3, 32'h0003_1235);
        rd(3'h3, 32'h0003_1235, "free limit");
        save(1'b1, 8'ha5, 1'b1, 32'h0003_1235, 1'b0);
        rd(3'h1, 32'ha5c3_1234, "link");
        save(1'b0, 8'h3c, 1'b0, 32'h0003_1236, 1'b1);
        rd(3'h2, 32'h0003_1236, "free head");
        rd(3'h1, 32'h3c03_1235, "link");
        check("link address", 32'h3004_8d40, previousContextAddress);
        restore(1'b1, 1'b1);
        restore(1'b0, 1'b0);
        $display("test context list done");
        wr(3'h4, 32'h0000_8000);
        wr(3'h5, 32'h0002_0000);
        check("stack flag", 0, {31'h0, interruptStackInUse});
        take_irq;
        check("save strobe", 1, {31'h0, stackSaveStrobe});
        check("saved stack", 32'h0000_8000, stackSaveValue);
        tick;
        check("stack pointer", 32'h0002_0000, stackPointer);
        check("stack flag", 1, {31'h0, interruptStackInUse});
        rd(3'h0, 32'h0000_02ff, "status word");
        check("partner copy", 32'h0000_8000, savedStackReg);
        wr(3'h5, 32'h0003_0000);
        rd(3'h5, 32'h0003_0000, "interrupt base");
        take_irq;
        check("save strobe", 0, {31'h0, stackSaveStrobe});
        tick;
        check("stack pointer", 32'h0002_0000, stackPointer);
        check("save count", 1, {24'h0, saveCountReg});
        stackWriteData = 32'h0000_4444;
        stackWrite = 1'b1;
        tick;
        stackWrite = 1'b0;
        rd(3'h4, 32'h0000_4444, "stack pointer");
        $display("test stack switch done");
        print_verdict;
    end
endmodule : tb

bind core_context_regs core_context_regs_assertions u_chk (.sys_clk, .rst, .moveWrite,
    .moveSelect, .moveReadData, .callExec, .interruptTake, .restoreExec, .restoreExpectUpper,
    .globalRegWriteReq, .protectionSetOneHot, .periphPrivilege, .privilegeReserved,
    .globalRegWriteAllow, .callDepthCounting, .freeHeadAddress, .previousContextAddress,
    .contextKindTrap, .stackSaveStrobe, .stackSaveValue, .stackPointer, .interruptStackInUse);

`default_nettype wire
